// *** sim/dbg_host_model.sv ***
// debug host model: issues serial command strobes one cycle wide
`timescale 1ns/1ps
`default_nettype none
module dbg_host_model (
    // clock and command side
    input  wire logic                CLK,
    output var dbg_regs_pkg::host_cmd_s CMD
);
    import dbg_regs_pkg::*;
    initial CMD = '0;
    // strobe launched after a falling edge, dropped at the next one
    task automatic send(input host_cmd_s c);
        @(negedge CLK);
        CMD = c;
        @(negedge CLK);
        CMD = '0;
    endtask
endmodule
`default_nettype wire

// *** sim/debug_port_status_breakpoint_regs_tb.sv ***
// self-checking bench for the debug register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module debug_port_status_breakpoint_regs_tb;
    import dbg_regs_pkg::*;
    logic      clk = 1'b0;
    logic      rst = 1'b1;
    host_cmd_s cmd;
    cpu_obs_s  cpu = '0;
    logic [7:0]  st, frd;
    logic [15:0] bk;
    logic        pa, cb, fb, tb, mr;
    int          errors = 0;
    int          cmp_count = 0;
    always #4 clk = ~clk;
    dbg_host_model dbg_host_model_i (.CLK(clk), .CMD(cmd));
    debug_port_status_breakpoint_regs debug_port_status_breakpoint_regs_i (
        .CLK(clk), .RST(rst), .CMD(cmd), .STATUS_RD(st), .BKPT_RD(bk),
        .FRST_RD(frd), .CPU(cpu), .PERMIT_ACTIVE(pa), .COMM_CLK_BUS(cb),
        .FORCE_BKPT(fb), .TAG_BKPT(tb), .MCU_RESET_REQ(mr));
    task automatic ctrl(input logic [7:0] d);
        dbg_host_model_i.send('{wr_ctrl: 1'b1, wdata: d, default: '0});
    endtask
    task automatic probe(input logic [15:0] a, input logic [1:0] e);
        logic [1:0] r;
        @(negedge clk);
        cpu.addr = a;
        cpu.addr_valid = 1'b1;
        @(negedge clk);
        r = {fb, tb};
        cpu.addr_valid = 1'b0;
        @(negedge clk);
        r = r | {fb, tb};
        `CHK("bkpt_req", e, r)
    endtask
    task automatic t_reset_vals();
        `CHK("status", 8'h00, st)
        `CHK("bkpt", 16'h0000, bk)
    endtask
    task automatic t_ctrl_bits();
        ctrl(8'hff);
        `CHK("status", 8'hb8, st)
        `CHK("permit_clk", 2'b11, {pa, cb})
        cpu.active = 1'b1;
        ctrl(8'h00);
        `CHK("status", 8'hc0, st)
        cpu.active = 1'b0;
        ctrl(8'h00);
        `CHK("status", 8'h80, st)
    endtask
    task automatic t_bkpt();
        dbg_host_model_i.send('{wr_bkpt: 1'b1, wbkpt: 16'h1234, default: '0});
        `CHK("bkpt", 16'h1234, bk)
        ctrl(8'h30);
        probe(16'h1235, 2'b00);
        probe(16'h1234, 2'b10);
        ctrl(8'h20);
        probe(16'h1234, 2'b01);
        ctrl(8'h10);
        probe(16'h1234, 2'b00);
    endtask
    task automatic t_wait_stop();
        cpu.wait_stop = 1'b1;
        cpu.mem_fail = 1'b1;
        @(negedge clk);
        cpu.mem_fail = 1'b0;
        @(negedge clk);
        `CHK("ws_wsf", 2'b11, st[2:1])
        cpu = '{bgnd_exit: 1'b1, active: 1'b1, default: '0};
        @(negedge clk);
        cpu.bgnd_exit = 1'b0;
        @(negedge clk);
        `CHK("act_ws", 2'b11, {st[6], st[2]})
        cpu = '{run: 1'b1, default: '0};
        @(negedge clk);
        cpu.run = 1'b0;
        @(negedge clk);
        `CHK("ws_wsf", 2'b00, st[2:1])
    endtask
    task automatic t_force_reset();
        dbg_host_model_i.send('{wr_frst: 1'b1, user_frst: 1'b1, wdata: 8'h01, default: '0});
        `CHK("mcu_reset", 1'b0, mr)
        dbg_host_model_i.send('{wr_frst: 1'b1, wdata: 8'h01, default: '0});
        `CHK("mcu_reset", 1'b1, mr)
        `CHK("frst_rd", 8'h00, frd)
    endtask
    task automatic t_mid_reset();
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        `CHK("status", 8'h00, st)
        `CHK("outs", 5'h00, {pa, cb, fb, tb, mr})
        cpu.active = 1'b1;
        ctrl(8'h80);
        `CHK("status", 8'h40, st)
        cpu.active = 1'b0;
        ctrl(8'h80);
        `CHK("status", 8'h80, st)
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog so a stalled run still reaches the verdict
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_reset_vals();
        t_ctrl_bits();
        t_bkpt();
        t_wait_stop();
        t_force_reset();
        t_mid_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// *** src/dbg_regs_pkg.sv ***
// package: constants and carrier types for the debug register block
package dbg_regs_pkg;

    // status/control and forced reset bit positions
    localparam int BIT_PERMIT  = 7;
    localparam int BIT_ACTIVE  = 6;
    localparam int BIT_BKPT_EN = 5;
    localparam int BIT_FTS     = 4;
    localparam int BIT_COMM_CLOCK_SELECT   = 3;
    localparam int BIT_WS      = 2;
    localparam int BIT_WSF     = 1;
    localparam int BIT_DVF     = 0;
    localparam int BIT_FRST    = 0;

    // reset values
    localparam logic [7:0]  CTRL_RESET = 8'h00;
    localparam logic [15:0] BKPT_RESET = 16'h0000;
    localparam logic [7:0]  FRST_READ  = 8'h00;

    // serial command strobes carried as a group
    typedef struct packed {
        logic        wr_ctrl;
        logic        wr_bkpt;
        logic        wr_frst;
        logic        user_frst;
        logic [7:0]  wdata;
        logic [15:0] wbkpt;
    } host_cmd_s;

    // cpu-side observations
    typedef struct packed {
        logic        active;
        logic        wait_stop;
        logic        bgnd_exit;
        logic        run;
        logic        mem_fail;
        logic        addr_valid;
        logic [15:0] addr;
    } cpu_obs_s;

    // state of the block apart from the status, breakpoint and forced reset readback registers
    typedef struct packed {
        logic        permit;
        logic        bkpt_en;
        logic        force_tag_select;
        logic        comm_clock_select;
        logic        ws;
        logic        wait_stop_failure;
        logic        active;
        logic [15:0] bkpt;
        logic        force_bp;
        logic        tag_bp;
        logic        mcu_rst;
    } state_s;

endpackage

// *** src/debug_port_status_breakpoint_regs.sv ***
// debug status/control, breakpoint match and forced reset registers
`timescale 1ns/1ps
`default_nettype none

module debug_port_status_breakpoint_regs (
    // clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RST,
    // serial debug command side
    input  wire dbg_regs_pkg::host_cmd_s CMD,
    output logic [7:0]                  STATUS_RD,
    output logic [15:0]                 BKPT_RD,
    output logic [7:0]                  FRST_RD,
    // cpu side
    input  wire dbg_regs_pkg::cpu_obs_s  CPU,
    output logic                        PERMIT_ACTIVE,
    output logic                        COMM_CLK_BUS,
    output logic                        FORCE_BKPT,
    output logic                        TAG_BKPT,
    output logic                        MCU_RESET_REQ
);
    import dbg_regs_pkg::*;

    state_s st_r;
    state_s st_nxt;

    // ************************************************************
    // match
    // ************************************************************
    function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] b);
        return a == b;
    endfunction

    logic hit;
    assign hit = st_r.bkpt_en && CPU.addr_valid && addr_hit(CPU.addr, st_r.bkpt);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.active = CPU.active;
        if (CMD.wr_ctrl) begin
            if (!st_r.active) begin
                // set only: once permitted, only a normal reset takes it away
                st_nxt.permit = st_r.permit | CMD.wdata[BIT_PERMIT];
            end
            st_nxt.bkpt_en = CMD.wdata[BIT_BKPT_EN];
            st_nxt.force_tag_select     = CMD.wdata[BIT_FTS];
            st_nxt.comm_clock_select   = CMD.wdata[BIT_COMM_CLOCK_SELECT];
        end
        if (CMD.wr_bkpt) begin
            st_nxt.bkpt = CMD.wbkpt;
        end
        // wait/stop status: hardware-only, command writes never touch it
        if (CPU.wait_stop || CPU.bgnd_exit) begin
            st_nxt.ws = 1'b1;
        end else if (CPU.run) begin
            st_nxt.ws = 1'b0;
        end
        // failure sticks until the cpu resumes; a new failure wins
        if (CPU.mem_fail) begin
            st_nxt.wait_stop_failure = 1'b1;
        end else if (CPU.run) begin
            st_nxt.wait_stop_failure = 1'b0;
        end
        st_nxt.force_bp = hit && st_r.force_tag_select;
        st_nxt.tag_bp   = hit && !st_r.force_tag_select;
        st_nxt.mcu_rst  = CMD.wr_frst && !CMD.user_frst && CMD.wdata[BIT_FRST];
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic [7:0] stat_rd_r;
    logic [15:0] bkpt_rd_r;
    logic [7:0] frst_rd_r;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            stat_rd_r <= CTRL_RESET;
            bkpt_rd_r <= BKPT_RESET;
            frst_rd_r <= FRST_READ;
        end else begin
            stat_rd_r <= {st_nxt.permit, st_nxt.active, st_nxt.bkpt_en, st_nxt.force_tag_select,
                          st_nxt.comm_clock_select, st_nxt.ws, st_nxt.wait_stop_failure, 1'b0};
            bkpt_rd_r <= st_nxt.bkpt;
            frst_rd_r <= FRST_READ;
        end
    end

    assign STATUS_RD     = stat_rd_r;
    assign BKPT_RD       = bkpt_rd_r;
    assign FRST_RD       = frst_rd_r;
    assign PERMIT_ACTIVE = st_r.permit;
    assign COMM_CLK_BUS  = st_r.comm_clock_select;
    assign FORCE_BKPT    = st_r.force_bp;
    assign TAG_BKPT      = st_r.tag_bp;
    assign MCU_RESET_REQ = st_r.mcu_rst;

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_ctrl_wr_active;
        CMD.wr_ctrl && st_r.active;
    endsequence

    a_permit_locked: assert property (@(posedge CLK) disable iff (RST)
        s_ctrl_wr_active |=> $stable(st_r.permit))
        else $error("permit changed in active mode");

    a_bkpt_off: assert property (@(posedge CLK) disable iff (RST)
        !st_r.bkpt_en |=> !FORCE_BKPT && !TAG_BKPT)
        else $error("breakpoint while disabled");

    a_force_hit: assert property (@(posedge CLK) disable iff (RST)
        (hit && st_r.force_tag_select) |=> FORCE_BKPT && !TAG_BKPT)
        else $error("force breakpoint missing");

    a_tag_hit: assert property (@(posedge CLK) disable iff (RST)
        (hit && !st_r.force_tag_select) |=> TAG_BKPT && !FORCE_BKPT)
        else $error("tag breakpoint missing");

    a_dvf_zero: assert property (@(posedge CLK) disable iff (RST)
        STATUS_RD[BIT_DVF] == 1'b0)
        else $error("data valid failure set");

    a_frst_zero: assert property (@(posedge CLK) disable iff (RST)
        FRST_RD == FRST_READ)
        else $error("forced reset reads nonzero");

    a_user_reset: assert property (@(posedge CLK) disable iff (RST)
        (CMD.wr_frst && CMD.user_frst) |=> !MCU_RESET_REQ)
        else $error("user write caused reset");

    a_host_reset: assert property (@(posedge CLK) disable iff (RST)
        (CMD.wr_frst && !CMD.user_frst && CMD.wdata[BIT_FRST]) |=> MCU_RESET_REQ)
        else $error("host reset not issued");

    a_ws_fail: assert property (@(posedge CLK) disable iff (RST)
        CPU.mem_fail |=> STATUS_RD[BIT_WSF])
        else $error("wait stop failure not set");

    a_active_view: assert property (@(posedge CLK) disable iff (RST)
        1'b1 |=> STATUS_RD[BIT_ACTIVE] == $past(CPU.active))
        else $error("active status mismatch");

    // ************************************************************
    // register contents
    // ************************************************************
    // permit can only be raised by the host while the cpu is outside active mode
    a_permit_set: assert property (@(posedge CLK) disable iff (RST)
        (CMD.wr_ctrl && !st_r.active && CMD.wdata[BIT_PERMIT]) |=> PERMIT_ACTIVE)
        else $error("permit not set");

    a_permit_sticky: assert property (@(posedge CLK) disable iff (RST)
        PERMIT_ACTIVE |=> PERMIT_ACTIVE)
        else $error("permit cleared without reset");

    a_comm_clock_select_write: assert property (@(posedge CLK) disable iff (RST)
        CMD.wr_ctrl |=> COMM_CLK_BUS == $past(CMD.wdata[BIT_COMM_CLOCK_SELECT]))
        else $error("clock select not written");

    a_comm_clock_select_view: assert property (@(posedge CLK) disable iff (RST)
        STATUS_RD[BIT_COMM_CLOCK_SELECT] == COMM_CLK_BUS)
        else $error("clock select readback mismatch");

    a_bken_write: assert property (@(posedge CLK) disable iff (RST)
        CMD.wr_ctrl |=> STATUS_RD[BIT_BKPT_EN] == $past(CMD.wdata[BIT_BKPT_EN]))
        else $error("breakpoint enable not written");

    a_fts_write: assert property (@(posedge CLK) disable iff (RST)
        CMD.wr_ctrl |=> STATUS_RD[BIT_FTS] == $past(CMD.wdata[BIT_FTS]))
        else $error("force tag select not written");

    a_bkpt_write: assert property (@(posedge CLK) disable iff (RST)
        CMD.wr_bkpt |=> BKPT_RD == $past(CMD.wbkpt))
        else $error("match address not written");

    a_bkpt_hold: assert property (@(posedge CLK) disable iff (RST)
        !CMD.wr_bkpt |=> $stable(BKPT_RD))
        else $error("match address changed without write");

    // ************************************************************
    // status bits
    // ************************************************************
    // with no cpu event in flight a control write must leave the WS and WSF status bits alone
    a_ro_bits: assert property (@(posedge CLK) disable iff (RST)
        (CMD.wr_ctrl && !CPU.wait_stop && !CPU.bgnd_exit && !CPU.run && !CPU.mem_fail)
        |=> STATUS_RD[BIT_WS:BIT_WSF] == $past(STATUS_RD[BIT_WS:BIT_WSF]))
        else $error("control write changed status bits");

    a_active_ro: assert property (@(posedge CLK) disable iff (RST)
        (CMD.wr_ctrl && CMD.wdata[BIT_ACTIVE] && !CPU.active) |=> !STATUS_RD[BIT_ACTIVE])
        else $error("active status written by host");

    a_ws_set: assert property (@(posedge CLK) disable iff (RST)
        (CPU.wait_stop || CPU.bgnd_exit) |=> STATUS_RD[BIT_WS])
        else $error("wait stop status not set");

    a_ws_clear: assert property (@(posedge CLK) disable iff (RST)
        (CPU.run && !CPU.wait_stop && !CPU.bgnd_exit) |=> !STATUS_RD[BIT_WS])
        else $error("wait stop status not cleared");

    a_bgnd_exit: assert property (@(posedge CLK) disable iff (RST)
        (CPU.bgnd_exit && CPU.active) |=> STATUS_RD[BIT_WS] && STATUS_RD[BIT_ACTIVE])
        else $error("background exit not reported");

    a_wsf_clear: assert property (@(posedge CLK) disable iff (RST)
        (CPU.run && !CPU.mem_fail) |=> !STATUS_RD[BIT_WSF])
        else $error("wait stop failure not cleared");

    a_wsf_hold: assert property (@(posedge CLK) disable iff (RST)
        (!CPU.run && !CPU.mem_fail) |=> STATUS_RD[BIT_WSF] == $past(STATUS_RD[BIT_WSF]))
        else $error("wait stop failure changed alone");

    // ************************************************************
    // breakpoint requests
    // ************************************************************
    sequence s_force_hit;
        hit && st_r.force_tag_select;
    endsequence

    sequence s_force_pulse;
        FORCE_BKPT ##1 !FORCE_BKPT;
    endsequence

    sequence s_tag_hit;
        hit && !st_r.force_tag_select;
    endsequence

    sequence s_tag_pulse;
        TAG_BKPT ##1 !TAG_BKPT;
    endsequence

    // an isolated hit gives exactly one cycle of request
    a_force_once: assert property (@(posedge CLK) disable iff (RST)
        s_force_hit ##1 !(hit && st_r.force_tag_select) |-> s_force_pulse)
        else $error("force request not a single pulse");

    a_tag_once: assert property (@(posedge CLK) disable iff (RST)
        s_tag_hit ##1 !(hit && !st_r.force_tag_select) |-> s_tag_pulse)
        else $error("tag request not a single pulse");

    a_match_exact: assert property (@(posedge CLK) disable iff (RST)
        (CPU.addr_valid && CPU.addr != st_r.bkpt) |=> !FORCE_BKPT && !TAG_BKPT)
        else $error("breakpoint on partial match");

    a_no_access: assert property (@(posedge CLK) disable iff (RST)
        !CPU.addr_valid |=> !FORCE_BKPT && !TAG_BKPT)
        else $error("breakpoint without bus access");

    a_force_excl: assert property (@(posedge CLK) disable iff (RST)
        FORCE_BKPT |-> !TAG_BKPT)
        else $error("force and tag together");

    // ************************************************************
    // forced reset
    // ************************************************************
    sequence s_host_reset;
        CMD.wr_frst && !CMD.user_frst && CMD.wdata[BIT_FRST];
    endsequence

    sequence s_reset_pulse;
        MCU_RESET_REQ ##1 !MCU_RESET_REQ;
    endsequence

    a_reset_once: assert property (@(posedge CLK) disable iff (RST)
        s_host_reset ##1 !CMD.wr_frst |-> s_reset_pulse)
        else $error("reset request not a single pulse");

    a_reset_source: assert property (@(posedge CLK) disable iff (RST)
        !CMD.wr_frst |=> !MCU_RESET_REQ)
        else $error("reset request without write");

    a_reset_bit_zero: assert property (@(posedge CLK) disable iff (RST)
        (CMD.wr_frst && !CMD.wdata[BIT_FRST]) |=> !MCU_RESET_REQ)
        else $error("reset request on zero write");

endmodule

`default_nettype wire
